// file: shared/ccm_defines.vh
// constants for the control-channel register access engine
// assumes a single 50 MHz system clock and a 1-byte-per-frame uart link
`ifndef CCM_DEFINES_VH
`define CCM_DEFINES_VH
// ****************
// frame values
// ****************
`define CCM_SYNC_BYTE 8'h79
`define CCM_ACK_BYTE 8'hC3
// ****************
// timing
// ****************
`define CCM_IDLE_BITS_LOG2 5
`define CCM_BITLEN_RST 16'h01B2
`define CCM_FRAME_LAST_BIT 4'hA
// ****************
// reset values and crc parameter defaults
// ****************
`define CCM_ERR_CNT_RST 8'h00
`define CCM_MSG_CNT_RST 16'h0000
`define CCM_CRC_POLY_DEF 8'h07
`define CCM_CRC_INIT_DEF 8'h00
`endif

// file: hw/ccm_access.v
// uart register access engine with optional crc and message counter
// register file sits outside: write strobes out, read data back one cycle
// after the read strobe; enables and threshold come from that register file
`include "ccm_defines.vh"

module ccm_access #(
  parameter [7:0] CRC_POLY = `CCM_CRC_POLY_DEF,
  parameter [7:0] CRC_INIT = `CCM_CRC_INIT_DEF
) (
  input wire clk_sys,
  input wire resetn,
  input wire uart_rx,
  output reg uart_tx_q,
  input wire [6:0] dev_addr,
  input wire crc_en,
  input wire msgcnt_en,
  input wire [7:0] err_thresh,
  input wire err_thresh_wr,
  input wire err_cnt_clr,
  input wire msg_cnt_clr,
  input wire i2c_dev_addr_seen,
  output reg reg_wr_q,
  output reg reg_rd_q,
  output reg [15:0] reg_addr_q,
  output reg [7:0] reg_wdata_q,
  input wire [7:0] reg_rdata,
  output reg [15:0] msg_cnt_q,
  output reg [7:0] err_cnt_q,
  output reg error_alert_n_q
);

  localparam [1:0] RX_IDLE = 2'd0;
  localparam [1:0] RX_CAL = 2'd1;
  localparam [1:0] RX_BITS = 2'd2;

  localparam [3:0] S_SYNC = 4'd0;
  localparam [3:0] S_DEV = 4'd1;
  localparam [3:0] S_RAL = 4'd2;
  localparam [3:0] S_RAH = 4'd3;
  localparam [3:0] S_CNT = 4'd4;
  localparam [3:0] S_MCL = 4'd5;
  localparam [3:0] S_MCH = 4'd6;
  localparam [3:0] S_DAT = 4'd7;
  localparam [3:0] S_CRC = 4'd8;
  localparam [3:0] S_ACK = 4'd9;
  localparam [3:0] S_APPLY = 4'd10;
  localparam [3:0] S_RMSG = 4'd11;
  localparam [3:0] S_RREQ = 4'd12;
  localparam [3:0] S_RDAT = 4'd13;
  localparam [3:0] S_RCRC = 4'd14;
  localparam [3:0] S_DROP = 4'd15;

  // one crc step, msb first
  function [7:0] crc8_f;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] r;
    begin
      r = c;
      for (i = 7; i >= 0; i = i - 1) begin
        if (r[7] ^ d[i])
          r = {r[6:0], 1'b0} ^ CRC_POLY;
        else
          r = {r[6:0], 1'b0};
      end
      crc8_f = r;
    end
  endfunction

  // ****************
  // input synchroniser and idle detect
  // ****************
  reg rx_meta_q;
  reg rx_s_q;
  reg rx_prev_q;
  reg [20:0] hi_cnt_q;
  reg idle_hit_q;
  reg [15:0] bitlen_q;
  wire [20:0] idle_lim = {bitlen_q, `CCM_IDLE_BITS_LOG2'b0};
  wire rx_fall = rx_prev_q & ~rx_s_q;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_meta_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_prev_q <= 1'b1;
      hi_cnt_q <= 21'h000000;
      idle_hit_q <= 1'b0;
    end else begin
      rx_meta_q <= uart_rx;
      rx_s_q <= rx_meta_q;
      rx_prev_q <= rx_s_q;
      idle_hit_q <= 1'b0;
      if (!rx_s_q)
        hi_cnt_q <= 21'h000000;
      else if (hi_cnt_q < idle_lim) begin
        hi_cnt_q <= hi_cnt_q + 21'h000001;
        if (hi_cnt_q == idle_lim - 21'h000001)
          idle_hit_q <= 1'b1;
      end
    end
  end

  // ****************
  // frame receiver with sync calibration
  // ****************
  reg [3:0] st_q;
  reg [1:0] rxst_q;
  reg [15:0] rcnt_q;
  reg [3:0] ridx_q;
  reg [8:0] rsh_q;
  reg rx_done_q;
  reg rx_ok_q;
  reg [7:0] rx_byte_q;
  reg seen_hi_q;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxst_q <= RX_IDLE;
      rcnt_q <= 16'h0000;
      ridx_q <= 4'h0;
      rsh_q <= 9'h000;
      rx_done_q <= 1'b0;
      rx_ok_q <= 1'b0;
      rx_byte_q <= 8'h00;
      seen_hi_q <= 1'b0;
      bitlen_q <= `CCM_BITLEN_RST;
    end else begin
      rx_done_q <= 1'b0;
      case (rxst_q)
        RX_IDLE: begin
          if (rx_fall) begin
            ridx_q <= 4'h0;
            seen_hi_q <= 1'b0;
            if (st_q == S_SYNC) begin
              rxst_q <= RX_CAL;
              rcnt_q <= 16'h0001;
            end else begin
              rxst_q <= RX_BITS;
              rcnt_q <= {1'b0, bitlen_q[15:1]};
            end
          end
        end
        RX_CAL: begin
          // start low, d0 high, d1 low: two falls are two bits apart
          rcnt_q <= rcnt_q + 16'h0001;
          if (rx_s_q)
            seen_hi_q <= 1'b1;
          if (&rcnt_q)
            rxst_q <= RX_IDLE;
          else if (seen_hi_q && rx_fall) begin
            bitlen_q <= {1'b0, rcnt_q[15:1]};
            rcnt_q <= {2'b00, rcnt_q[15:2]};
            rsh_q <= 9'h001;
            ridx_q <= 4'h2;
            rxst_q <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (rcnt_q != 16'h0000)
            rcnt_q <= rcnt_q - 16'h0001;
          else begin
            rcnt_q <= bitlen_q - 16'h0001;
            ridx_q <= ridx_q + 4'h1;
            if (ridx_q == 4'h0) begin
              if (rx_s_q)
                rxst_q <= RX_IDLE;
            end else if (ridx_q == `CCM_FRAME_LAST_BIT) begin
              rxst_q <= RX_IDLE;
              rx_done_q <= 1'b1;
              rx_byte_q <= rsh_q[7:0];
              rx_ok_q <= rx_s_q & ~(^rsh_q);
            end else
              rsh_q[ridx_q - 4'h1] <= rx_s_q;
          end
        end
        default: rxst_q <= RX_IDLE;
      endcase
    end
  end

  // ****************
  // frame transmitter
  // ****************
  reg tx_go_q;
  reg [7:0] tx_byte_q;
  reg tx_busy_q;
  reg [15:0] tcnt_q;
  reg [3:0] tidx_q;
  reg [9:0] tsh_q;
  wire tx_ready = ~tx_busy_q & ~tx_go_q;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      uart_tx_q <= 1'b1;
      tx_busy_q <= 1'b0;
      tcnt_q <= 16'h0000;
      tidx_q <= 4'h0;
      tsh_q <= 10'h3FF;
    end else if (tx_go_q) begin
      uart_tx_q <= 1'b0;
      tsh_q <= {1'b1, ^tx_byte_q, tx_byte_q};
      tx_busy_q <= 1'b1;
      tcnt_q <= bitlen_q - 16'h0001;
      tidx_q <= 4'h0;
    end else if (tx_busy_q) begin
      if (tcnt_q != 16'h0000)
        tcnt_q <= tcnt_q - 16'h0001;
      else begin
        tcnt_q <= bitlen_q - 16'h0001;
        tidx_q <= tidx_q + 4'h1;
        if (tidx_q == `CCM_FRAME_LAST_BIT) begin
          tx_busy_q <= 1'b0;
          uart_tx_q <= 1'b1;
        end else begin
          uart_tx_q <= tsh_q[0];
          tsh_q <= {1'b1, tsh_q[9:1]};
        end
      end
    end
  end

  // ****************
  // packet sequencer
  // ****************
  reg rw_q;
  reg [7:0] cnt_q;
  reg [7:0] idx_q;
  reg [7:0] mcl_q;
  reg [7:0] crc_q;
  reg sub_q;
  reg err_evt_q;
  reg cnt_evt_q;
  reg [7:0] buf_mem [0:255];
  wire rx_state = (st_q <= S_CRC) || (st_q == S_DROP);
  wire last_byte = (idx_q == cnt_q - 8'h01);
  wire [7:0] crc_next = crc8_f(crc_q, rx_byte_q);

  always @(posedge clk_sys) begin
    if (st_q == S_DAT && rx_done_q && rx_ok_q)
      buf_mem[idx_q] <= rx_byte_q;
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= S_SYNC;
      rw_q <= 1'b0;
      cnt_q <= 8'h00;
      idx_q <= 8'h00;
      mcl_q <= 8'h00;
      crc_q <= 8'h00;
      sub_q <= 1'b0;
      err_evt_q <= 1'b0;
      cnt_evt_q <= 1'b0;
      tx_go_q <= 1'b0;
      tx_byte_q <= 8'h00;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_addr_q <= 16'h0000;
      reg_wdata_q <= 8'h00;
    end else begin
      err_evt_q <= 1'b0;
      cnt_evt_q <= 1'b0;
      tx_go_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      if (rx_state && idle_hit_q)
        st_q <= S_SYNC;
      else if (rx_state && rx_done_q && !rx_ok_q && st_q != S_SYNC)
        st_q <= S_DROP;
      else begin
        case (st_q)
          S_SYNC: if (rx_done_q) begin
            // recalibrates on the next frame unless sync is exact
            if (rx_ok_q && rx_byte_q == `CCM_SYNC_BYTE) begin
              st_q <= S_DEV;
              crc_q <= crc8_f(CRC_INIT, rx_byte_q);
            end
          end
          S_DEV: if (rx_done_q) begin
            rw_q <= rx_byte_q[0];
            crc_q <= crc_next;
            st_q <= (rx_byte_q[7:1] == dev_addr) ? S_RAL : S_DROP;
          end
          S_RAL: if (rx_done_q) begin
            reg_addr_q[7:0] <= rx_byte_q;
            crc_q <= crc_next;
            st_q <= S_RAH;
          end
          S_RAH: if (rx_done_q) begin
            reg_addr_q[15:8] <= rx_byte_q;
            crc_q <= crc_next;
            st_q <= S_CNT;
          end
          S_CNT: if (rx_done_q) begin
            cnt_q <= rx_byte_q;
            idx_q <= 8'h00;
            sub_q <= 1'b0;
            if (rx_byte_q == 8'h00)
              st_q <= S_DROP;
            else if (rw_q)
              st_q <= S_ACK;
            else
              st_q <= msgcnt_en ? S_MCL : S_DAT;
          end
          S_MCL: if (rx_done_q) begin
            mcl_q <= rx_byte_q;
            crc_q <= crc_next;
            st_q <= S_MCH;
          end
          S_MCH: if (rx_done_q) begin
            crc_q <= crc_next;
            if ({rx_byte_q, mcl_q} != msg_cnt_q) begin
              err_evt_q <= 1'b1;
              st_q <= S_DROP;
            end else
              st_q <= S_DAT;
          end
          S_DAT: if (rx_done_q) begin
            crc_q <= crc_next;
            idx_q <= idx_q + 8'h01;
            if (crc_en) begin
              idx_q <= idx_q;
              st_q <= S_CRC;
            end else if (last_byte)
              st_q <= S_ACK;
          end
          S_CRC: if (rx_done_q) begin
            crc_q <= CRC_INIT;
            idx_q <= idx_q + 8'h01;
            if (rx_byte_q != crc_q) begin
              err_evt_q <= 1'b1;
              st_q <= S_DROP;
            end else
              st_q <= last_byte ? S_ACK : S_DAT;
          end
          S_ACK: begin
            if (!sub_q) begin
              tx_byte_q <= `CCM_ACK_BYTE;
              tx_go_q <= 1'b1;
              sub_q <= 1'b1;
            end else if (tx_ready) begin
              sub_q <= 1'b0;
              idx_q <= 8'h00;
              if (!rw_q)
                st_q <= S_APPLY;
              else
                st_q <= msgcnt_en ? S_RMSG : S_RREQ;
            end
          end
          S_APPLY: begin
            reg_wr_q <= 1'b1;
            reg_wdata_q <= buf_mem[idx_q];
            if (idx_q != 8'h00)
              reg_addr_q <= reg_addr_q + 16'h0001;
            idx_q <= idx_q + 8'h01;
            if (last_byte) begin
              cnt_evt_q <= 1'b1;
              st_q <= S_SYNC;
            end
          end
          S_RMSG: if (tx_ready) begin
            // counter goes out low byte first, ahead of data
            tx_byte_q <= sub_q ? msg_cnt_q[15:8] : msg_cnt_q[7:0];
            crc_q <= crc8_f(crc_q, sub_q ? msg_cnt_q[15:8] :
              msg_cnt_q[7:0]);
            tx_go_q <= 1'b1;
            sub_q <= ~sub_q;
            if (sub_q)
              st_q <= S_RREQ;
          end
          S_RREQ: begin
            if (!sub_q) begin
              reg_rd_q <= 1'b1;
              sub_q <= 1'b1;
            end else begin
              sub_q <= 1'b0;
              st_q <= S_RDAT;
            end
          end
          S_RDAT: if (tx_ready) begin
            tx_byte_q <= reg_rdata;
            crc_q <= crc8_f(idx_q == 8'h00 ? crc_q : CRC_INIT,
              reg_rdata);
            tx_go_q <= 1'b1;
            if (crc_en)
              st_q <= S_RCRC;
            else begin
              idx_q <= idx_q + 8'h01;
              reg_addr_q <= reg_addr_q + 16'h0001;
              st_q <= last_byte ? S_SYNC : S_RREQ;
              cnt_evt_q <= last_byte;
            end
          end
          S_RCRC: if (tx_ready) begin
            tx_byte_q <= crc_q;
            tx_go_q <= 1'b1;
            idx_q <= idx_q + 8'h01;
            reg_addr_q <= reg_addr_q + 16'h0001;
            st_q <= last_byte ? S_SYNC : S_RREQ;
            cnt_evt_q <= last_byte;
          end
          S_DROP: ;
          default: st_q <= S_SYNC;
        endcase
      end
    end
  end

  // ****************
  // message and error counters
  // ****************
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      msg_cnt_q <= `CCM_MSG_CNT_RST;
      err_cnt_q <= `CCM_ERR_CNT_RST;
      error_alert_n_q <= 1'b1;
    end else begin
      if (msg_cnt_clr)
        msg_cnt_q <= {15'h0000, cnt_evt_q | i2c_dev_addr_seen};
      else
        msg_cnt_q <= msg_cnt_q + {15'h0000, cnt_evt_q}
          + {15'h0000, i2c_dev_addr_seen};
      if (err_cnt_clr || err_thresh_wr)
        err_cnt_q <= {7'h00, err_evt_q};
      else if (err_evt_q && err_cnt_q != 8'hFF)
        err_cnt_q <= err_cnt_q + 8'h01;
      error_alert_n_q <= ~(err_thresh != 8'h00 &&
        err_cnt_q >= err_thresh);
    end
  end

endmodule // ccm_access

// file: verification/ccm_chk_sva.sv
// port checker for the uart access engine
// assumes the host runs 16 clk_sys cycles per uart bit
module ccm_chk (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic uart_tx_q,
  input wire logic [7:0] err_thresh,
  input wire logic err_thresh_wr,
  input wire logic err_cnt_clr,
  input wire logic msg_cnt_clr,
  input wire logic reg_wr_q,
  input wire logic reg_rd_q,
  input wire logic [15:0] msg_cnt_q,
  input wire logic [7:0] err_cnt_q,
  input wire logic error_alert_n_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hi_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ****************
  // cycles since tx was last low
  // ****************
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hi_q <= 16'h0000;
    end else if (!uart_tx_q) begin
      hi_q <= 16'h0000;
    end else if (hi_q != 16'hFFFF) begin
      hi_q <= hi_q + 16'h0001;
    end
  end
  // ****************
  // properties
  // ****************
  property p_no_overlap;
    !(reg_wr_q && reg_rd_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("write and read strobes together");
  property p_wr_after_ack;
    reg_wr_q |-> hi_q >= 16'h000F && hi_q <= 16'h0050;
  endproperty
  a_wr_after_ack: assert property (p_wr_after_ack)
    else $error("write strobe not right after ack");
  property p_ack_start;
    $fell(uart_tx_q) && hi_q > 16'h0028 |-> ##14 !uart_tx_q ##[1:3] uart_tx_q;
  endproperty
  a_ack_start: assert property (p_ack_start)
    else $error("ack start bit length wrong");
  property p_alert_on;
    err_thresh != 8'h00 && err_cnt_q >= err_thresh |=> !error_alert_n_q;
  endproperty
  a_alert_on: assert property (p_alert_on)
    else $error("alert missing at threshold");
  property p_alert_off;
    err_thresh == 8'h00 || err_cnt_q < err_thresh |=> error_alert_n_q;
  endproperty
  a_alert_off: assert property (p_alert_off)
    else $error("alert below threshold");
  property p_err_clr;
    err_cnt_clr || err_thresh_wr |=> err_cnt_q <= 8'h01;
  endproperty
  a_err_clr: assert property (p_err_clr)
    else $error("error count not cleared");
  property p_err_step;
    !err_cnt_clr && !err_thresh_wr |=> err_cnt_q - $past(err_cnt_q) <= 8'h01;
  endproperty
  a_err_step: assert property (p_err_step)
    else $error("error count jumped");
  property p_msg_clr;
    msg_cnt_clr |=> msg_cnt_q <= 16'h0001;
  endproperty
  a_msg_clr: assert property (p_msg_clr)
    else $error("message count not cleared");
  c_wr: cover property (reg_wr_q);
  c_rd: cover property (reg_rd_q);
  c_alarm: cover property (!error_alert_n_q);
endmodule // ccm_chk

bind ccm_access ccm_chk u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .uart_tx_q(uart_tx_q),
  .err_thresh(err_thresh), .err_thresh_wr(err_thresh_wr),
  .err_cnt_clr(err_cnt_clr), .msg_cnt_clr(msg_cnt_clr),
  .reg_wr_q(reg_wr_q), .reg_rd_q(reg_rd_q), .msg_cnt_q(msg_cnt_q),
  .err_cnt_q(err_cnt_q), .error_alert_n_q(error_alert_n_q)
);

// file: verification/ccm_host.sv
// host uart model: sends packets, receives answer frames
// assumes 16 clk_sys cycles per bit; line idles high
module ccm_host (
  input wire logic clk_sys,
  output logic uart_rx,
  input wire logic uart_tx_q
);
  timeunit 1ns;
  timeprecision 1ps;
  initial uart_rx = 1'b1;
  // ****************
  // frames out, gap of idle bits first
  // ****************
  task automatic send_pkt(input logic [7:0] b[$], input int bad, gap);
    logic [10:0] f;
    repeat (gap * 16) @(posedge clk_sys);
    foreach (b[i]) begin
      f = {1'b1, ^b[i] ^ (i == bad), b[i], 1'b0};
      for (int k = 0; k < 11; k++) begin
        uart_rx <= f[k];
        repeat (16) @(posedge clk_sys);
      end
    end
  endtask
  // ****************
  // one frame in, or none within 40 bits
  // ****************
  task automatic recv(output logic [7:0] v, output logic got);
    int n;
    got = 1'b0;
    v = 8'h00;
    n = 0;
    while (uart_tx_q !== 1'b0 && n < 640) begin
      @(negedge clk_sys);
      n++;
    end
    if (uart_tx_q === 1'b0) begin
      got = 1'b1;
      repeat (8) @(negedge clk_sys);
      for (int k = 0; k < 8; k++) begin
        repeat (16) @(negedge clk_sys);
        v[k] = uart_tx_q;
      end
      repeat (32) @(negedge clk_sys);
    end
  endtask
endmodule // ccm_host

// file: verification/tb_top.sv
// self-checking bench for the uart access engine
// assumes ccm_host as the uart host, register file modelled here
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h2A;
  logic clk_sys, resetn, uart_rx, uart_tx_q, crc_en, msgcnt_en;
  logic err_thresh_wr, err_cnt_clr, msg_cnt_clr, i2c_dev_addr_seen;
  logic reg_wr_q, reg_rd_q, error_alert_n_q;
  logic [7:0] err_thresh, reg_wdata_q, reg_rdata, err_cnt_q;
  logic [15:0] reg_addr_q, msg_cnt_q;
  logic [7:0] q[$];
  logic [23:0] wq[$];
  int n_fail, cmp_count;
  int n_rd = 0;
  ccm_access dut (
    .clk_sys(clk_sys), .resetn(resetn), .uart_rx(uart_rx),
    .uart_tx_q(uart_tx_q), .dev_addr(DEV), .crc_en(crc_en),
    .msgcnt_en(msgcnt_en), .err_thresh(err_thresh),
    .err_thresh_wr(err_thresh_wr), .err_cnt_clr(err_cnt_clr),
    .msg_cnt_clr(msg_cnt_clr), .i2c_dev_addr_seen(i2c_dev_addr_seen),
    .reg_wr_q(reg_wr_q), .reg_rd_q(reg_rd_q), .reg_addr_q(reg_addr_q),
    .reg_wdata_q(reg_wdata_q), .reg_rdata(reg_rdata),
    .msg_cnt_q(msg_cnt_q), .err_cnt_q(err_cnt_q),
    .error_alert_n_q(error_alert_n_q)
  );
  ccm_host host (.clk_sys(clk_sys), .uart_rx(uart_rx), .uart_tx_q(uart_tx_q));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // register file: log writes, answer reads next cycle
  always @(posedge clk_sys) begin
    reg_rdata <= reg_addr_q[7:0] ^ 8'h5A;
    if (reg_rd_q === 1'b1) begin
      n_rd <= n_rd + 1;
    end
    if (reg_wr_q === 1'b1) begin
      wq.push_back({reg_addr_q, reg_wdata_q});
    end
  end
  // ****************
  // helpers
  // ****************
  function automatic logic [7:0] crc(input logic [7:0] c, d);
    c = c ^ d;
    for (int k = 0; k < 8; k++)
      c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic chk(input string nm, input logic [23:0] e, g);
    cmp_count++;
    if (e !== g) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic reply(input logic [7:0] e);
    logic [7:0] v;
    logic g;
    host.recv(v, g);
    chk("reply", {1'b1, e}, {g, v});
  endtask
  task automatic silent;
    logic [7:0] v;
    logic g;
    host.recv(v, g);
    chk("silence", 0, g);
  endtask
  task automatic wr2(input logic [15:0] mc, input logic [7:0] x);
    logic [7:0] c;
    q = '{8'h79, {DEV, 1'b0}, 8'h20, 8'h01, 8'h02, mc[7:0], mc[15:8]};
    c = 8'h00;
    foreach (q[i])
      if (i != 4)
        c = crc(c, q[i]);
    q.push_back(8'h3C);
    q.push_back(crc(c, 8'h3C));
    q.push_back(8'hC4);
    q.push_back(crc(8'h00, 8'hC4) ^ x);
    host.send_pkt(q, -1, 34);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_errors;
    q = '{8'h79, {DEV, 1'b0}, 8'h34, 8'h12, 8'h01, 8'h66};
    host.send_pkt(q, 2, 34);
    host.send_pkt(q, -1, 8);
    silent();
    q[0] = 8'h55;
    host.send_pkt(q, -1, 34);
    silent();
    q[0] = 8'h79;
    q[1] = {~DEV, 1'b0};
    host.send_pkt(q, -1, 34);
    silent();
    q[1] = {DEV, 1'b0};
    q[4] = 8'h00;
    host.send_pkt(q, -1, 34);
    silent();
    chk("writes", 0, 24'(wq.size()));
  endtask
  task automatic t_write;
    q = '{8'h79, {DEV, 1'b0}, 8'h34, 8'h12, 8'h02, 8'hA5, 8'h5B};
    host.send_pkt(q, -1, 34);
    reply(8'hC3);
    chk("early writes", 0, 24'(wq.size()));
    repeat (20) @(posedge clk_sys);
    chk("write 0", 24'h1234A5, wq[0]);
    chk("write 1", 24'h12355B, wq[1]);
  endtask
  task automatic t_read;
    q = '{8'h79, {DEV, 1'b1}, 8'h40, 8'h00, 8'h02};
    host.send_pkt(q, -1, 34);
    reply(8'hC3);
    reply(8'h1A);
    reply(8'h1B);
    chk("reads", 2, 24'(n_rd));
  endtask
  task automatic t_crc;
    logic [7:0] c;
    @(posedge clk_sys);
    crc_en <= 1'b1;
    msgcnt_en <= 1'b1;
    err_thresh <= 8'h02;
    err_thresh_wr <= 1'b1;
    msg_cnt_clr <= 1'b1;
    @(posedge clk_sys);
    err_thresh_wr <= 1'b0;
    msg_cnt_clr <= 1'b0;
    i2c_dev_addr_seen <= 1'b1;
    @(posedge clk_sys);
    i2c_dev_addr_seen <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("msg count", 1, msg_cnt_q);
    wr2(16'h0001, 8'h00);
    reply(8'hC3);
    repeat (20) @(posedge clk_sys);
    chk("crc write", 24'h0121C4, wq[3]);
    chk("msg count", 2, msg_cnt_q);
    wr2(16'h0002, 8'h01);
    silent();
    chk("err count", 1, err_cnt_q);
    wr2(16'h0009, 8'h00);
    silent();
    chk("err count", 2, err_cnt_q);
    chk("alert", 0, error_alert_n_q);
    chk("writes", 4, 24'(wq.size()));
    @(posedge clk_sys);
    err_cnt_clr <= 1'b1;
    @(posedge clk_sys);
    err_cnt_clr <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("alert", 1, {err_cnt_q, error_alert_n_q});
    q = '{8'h79, {DEV, 1'b1}, 8'h20, 8'h01, 8'h02, 8'h00, 8'h7A};
    c = 8'h00;
    foreach (q[i])
      c = crc(c, q[i]);
    q = '{8'h79, {DEV, 1'b1}, 8'h20, 8'h01, 8'h01};
    host.send_pkt(q, -1, 34);
    reply(8'hC3);
    reply(8'h02);
    reply(8'h00);
    reply(8'h7A);
    reply(c);
    chk("reads", 3, 24'(n_rd));
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
  initial begin
    n_fail = 0;
    cmp_count = 0;
    resetn = 1'b0;
    {crc_en, msgcnt_en, err_thresh_wr, err_cnt_clr} = 4'h0;
    {msg_cnt_clr, i2c_dev_addr_seen} = 2'h0;
    err_thresh = 8'h00;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    t_errors();
    t_write();
    t_read();
    t_crc();
    wrap_up();
  end
endmodule // tb_top
